// *** src/lmc_pkg.sv ***
// constants and types shared by the line mode controller
package lmc_pkg;
   // clock and time base
   localparam int unsigned CLK_NS      = 10;
   localparam int unsigned MS_NS       = 1000000;
   localparam int unsigned MS_CYC      = MS_NS / CLK_NS;
   localparam int unsigned RING_HZ     = 25;
   localparam int unsigned RING_HALF_V = 1000 / (2 * RING_HZ);
   localparam logic [7:0]  RING_HALF_MS = RING_HALF_V[7:0];
   // zero crossings of sustained off-hook before ring trip (< 2 periods)
   localparam logic [1:0]  TRIP_ZC      = 2'h3;

   // register byte offsets
   localparam logic [4:0] FEED0_OFS   = 5'h00;
   localparam logic [4:0] FEED1_OFS   = 5'h04;
   localparam logic [4:0] EXT2_OFS    = 5'h08;
   localparam logic [4:0] SIG_OFS     = 5'h0c;
   localparam logic [4:0] MASK_OFS    = 5'h10;
   localparam logic [4:0] PERSIST_OFS = 5'h14;
   localparam logic [4:0] PIO_OFS     = 5'h18;
   localparam logic [4:0] STAT_OFS    = 5'h1c;

   // field positions
   localparam int FEED0_POL  = 7;
   localparam int FEED0_BB   = 6;
   localparam int FEED0_LAW  = 0;
   localparam int FEED1_KIND = 7;
   localparam int FEED1_TONE = 6;
   localparam int FEED1_METER_SLOPE_DISABLE = 5;
   localparam int EXT2_REXT  = 7;
   localparam int SIG_HOOK   = 0;
   localparam int SIG_RES    = 1;
   localparam int SIG_GNK    = 2;
   localparam int MB0        = 2;
   localparam int MB1        = 3;
   localparam int MB2        = 4;
   localparam int UP_IO2     = 7;
   localparam int UP_IO1     = 6;
   localparam int UP_IN1     = 5;
   localparam int UP_HOOK    = 4;
   localparam int UP_GNK     = 3;
   localparam int UP_SIGNALLING_SUMMARY_IRQ    = 2;

   // values after reset
   localparam logic [7:0] DUP_RST_MS = 8'h0a;
   localparam logic [7:0] GNK_RST_MS = 8'h14;
   localparam logic [2:0] MASK_RST   = 3'h7;
   localparam logic [7:0] UP_RST     = 8'h04;

   // ternary levels and {pin1,pin2} codes
   localparam logic [1:0] LVL_LOW  = 2'h0;
   localparam logic [1:0] LVL_MID  = 2'h1;
   localparam logic [1:0] LVL_HIGH = 2'h2;
   localparam logic [3:0] POWERDOWN_HIGH_Z_CODE = {LVL_LOW, LVL_LOW};
   localparam logic [3:0] POWERDOWN_RESISTIVE_CODE = {LVL_LOW, LVL_MID};
   localparam logic [3:0] ACT_CODE  = {LVL_HIGH, LVL_LOW};
   localparam logic [3:0] HIT_CODE  = {LVL_MID, LVL_HIGH};
   localparam logic [3:0] BB_CODE   = {LVL_MID, LVL_LOW};

   typedef enum logic [2:0] {
      MD_PD_HZ, MD_PD_RES, MD_ACTIVE, MD_ACT_METER,
      MD_GND_START, MD_RING_PAUSE, MD_RING_BURST
   } lmc_mode_t;
endpackage : lmc_pkg

// *** src/lmc_line_mode_ctrl.sv ***
// line mode controller: mode decode, line driver codes, ringing, debounce
module lmc_line_mode_ctrl #(
   parameter int unsigned TICK_CYC = lmc_pkg::MS_CYC
) (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   // register bus
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // serial command link
   input  wire logic        link_clk,
   input  wire logic        link_fs,
   input  wire logic        link_dd,
   output logic             link_du_o,
   output logic             link_du_oe,
   // line supervision inputs
   input  wire logic        hook_raw,
   input  wire logic        gnd_key_raw,
   // line driver control
   output logic [1:0]       line_ctrl_pin1,
   output logic [1:0]       line_ctrl_pin2,
   output logic             polarity_rev,
   output logic             ac_loop_on,
   output logic             dc_loop_on,
   output logic             voice_loopback,
   output logic             ring_burst_on,
   output logic             mulaw_sel,
   output logic             teletax_on,
   output logic             meter_tone_sel,
   output logic             meter_slope_off,
   // digital pins
   input  wire logic        in1_pin,
   output logic             fixed_out_o,
   output logic             fixed_out_oe,
   input  wire logic        processor_io_pin1,
   input  wire logic        frontend_io_pin1_i,
   output logic             frontend_io_pin1_o,
   output logic             frontend_io_pin1_oe,
   input  wire logic        frontend_io_pin2_i,
   output logic             frontend_io_pin2_o,
   output logic             frontend_io_pin2_oe
);
   typedef lmc_pkg::lmc_mode_t lmc_md_t;

   function automatic lmc_md_t decode_mode(input logic [2:0] m);
      unique case (m)
         3'h7:    decode_mode = lmc_pkg::MD_PD_RES;
         3'h2:    decode_mode = lmc_pkg::MD_ACTIVE;
         3'h6:    decode_mode = lmc_pkg::MD_ACT_METER;
         3'h4:    decode_mode = lmc_pkg::MD_GND_START;
         3'h1:    decode_mode = lmc_pkg::MD_RING_PAUSE;
         3'h5:    decode_mode = lmc_pkg::MD_RING_BURST;
         default: decode_mode = lmc_pkg::MD_PD_HZ;
      endcase
   endfunction : decode_mode

   function automatic logic is_pd(input lmc_md_t m);
      is_pd = (m == lmc_pkg::MD_PD_HZ) || (m == lmc_pkg::MD_PD_RES);
   endfunction : is_pd

   function automatic logic is_ring(input lmc_md_t m);
      is_ring = (m == lmc_pkg::MD_RING_PAUSE) ||
                (m == lmc_pkg::MD_RING_BURST);
   endfunction : is_ring

   // synchronisers: {zc, io2, io1, in1, gnk, hook, dd, fs, lclk}
   logic [8:0] sync1_q, sync2_q;
   logic       lclk_d_q, zc_d_q;
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync1_q  <= '0;
         sync2_q  <= '0;
         lclk_d_q <= 1'b0;
         zc_d_q   <= 1'b0;
      end else begin
         sync1_q  <= {processor_io_pin1, frontend_io_pin2_i,
                      frontend_io_pin1_i, in1_pin, gnd_key_raw,
                      hook_raw, link_dd, link_fs, link_clk};
         sync2_q  <= sync1_q;
         lclk_d_q <= sync2_q[0];
         zc_d_q   <= sync2_q[8];
      end
   end
   wire lclk_rise = sync2_q[0] & ~lclk_d_q;
   wire lclk_fall = ~sync2_q[0] & lclk_d_q;
   wire fs_s = sync2_q[1];
   wire dd_s = sync2_q[2];
   wire hook_s = sync2_q[3];
   wire gnk_s = sync2_q[4];

   // configuration registers
   logic [7:0] feed0_q, feed1_q, ext2_q, dup_ms_q, gnk_ms_q;
   logic [2:0] mask_q, sig_q;
   logic [3:0] pio_q;   // {io2 oe, io1 oe, io2 val, io1 val}
   logic       fixed_val_q, sop_seen_q, signalling_summary_irq_q;
   logic [7:0] downstream_command_byte_q;

   // bus handshake: one wait cycle, then an answer cycle
   wire req    = avs_read | avs_write;
   wire take   = req & ~avs_waitrequest;
   wire wr_hit = avs_write & ~avs_waitrequest;
   wire rd_sig = avs_read & ~avs_waitrequest &
                 (avs_address == lmc_pkg::SIG_OFS);

   // register writes stay live in every mode, power down included
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         avs_waitrequest <= 1'b1;
         feed0_q     <= '0;
         feed1_q     <= '0;
         ext2_q      <= '0;
         mask_q      <= lmc_pkg::MASK_RST;
         dup_ms_q    <= lmc_pkg::DUP_RST_MS;
         gnk_ms_q    <= lmc_pkg::GNK_RST_MS;
         pio_q       <= '0;
         fixed_val_q <= 1'b0;
         sop_seen_q  <= 1'b0;
      end else begin
         avs_waitrequest <= ~(req & avs_waitrequest);
         if (wr_hit) begin
            unique case (avs_address)
               lmc_pkg::FEED0_OFS: feed0_q  <= avs_writedata[7:0];
               lmc_pkg::FEED1_OFS: feed1_q  <= avs_writedata[7:0];
               lmc_pkg::EXT2_OFS:  ext2_q   <= avs_writedata[7:0];
               lmc_pkg::MASK_OFS:  mask_q   <= avs_writedata[2:0];
               lmc_pkg::PERSIST_OFS: begin
                  dup_ms_q <= avs_writedata[7:0];
                  gnk_ms_q <= avs_writedata[15:8];
               end
               lmc_pkg::PIO_OFS: begin
                  pio_q       <= avs_writedata[3:0];
                  fixed_val_q <= avs_writedata[4];
                  sop_seen_q  <= 1'b1;
               end
               default: ;
            endcase
            if (avs_address == lmc_pkg::FEED0_OFS ||
                avs_address == lmc_pkg::FEED1_OFS ||
                avs_address == lmc_pkg::EXT2_OFS)
               sop_seen_q <= 1'b1;
         end
      end
   end

   // millisecond tick; slower rates run off this enable
   logic [31:0] tick_cnt_q;
   logic        tick_q;
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tick_cnt_q <= '0;
         tick_q     <= 1'b0;
      end else begin
         tick_q     <= (tick_cnt_q == 32'(TICK_CYC - 1));
         tick_cnt_q <= tick_q ? '0 : tick_cnt_q + 32'h1;
      end
   end

   // serial link: byte msb first from frame sync, upstream on falls
   logic [6:0] dsh_q;
   logic [3:0] bit_q;
   logic [7:0] ush_q, up_byte;
   logic [3:0] ubit_q;
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         dsh_q      <= '0;
         bit_q      <= 4'h8;
         downstream_command_byte_q     <= '0;
         ush_q      <= '0;
         ubit_q     <= '0;
         link_du_o  <= 1'b0;
         link_du_oe <= 1'b0;
      end else begin
         if (lclk_rise) begin
            if (fs_s) begin
               dsh_q <= {6'h0, dd_s};
               bit_q <= 4'h1;
               ush_q <= up_byte;
               ubit_q <= 4'h8;
               link_du_oe <= 1'b1;
            end else if (bit_q < 4'h8) begin
               dsh_q <= {dsh_q[5:0], dd_s};
               bit_q <= bit_q + 4'h1;
               if (bit_q == 4'h7)
                  downstream_command_byte_q <= {dsh_q, dd_s};
            end
         end
         // upstream counts its own falls: the eighth one follows the
         // last downstream rise, so the bit counter cannot gate it
         if (lclk_fall && ubit_q != 4'h0) begin
            link_du_o <= ush_q[7];
            ush_q     <= {ush_q[6:0], 1'b0};
            ubit_q    <= ubit_q - 4'h1;
         end
      end
   end

   // mode tracking, ringing and ring trip
   wire     lmc_md_t mode_req = decode_mode({downstream_command_byte_q[lmc_pkg::MB2],
                              downstream_command_byte_q[lmc_pkg::MB1], downstream_command_byte_q[lmc_pkg::MB0]});
   logic    trip_q, ring_on_q, hook_q, gnk_q;
   lmc_md_t mode_q;
   wire     lmc_md_t mode_eff = trip_q ? lmc_pkg::MD_ACTIVE
                                       : mode_req;
   wire   ext_ring = ext2_q[lmc_pkg::EXT2_REXT];
   logic [7:0] ring_ms_q;
   logic [1:0] trip_zc_q;
   logic       zc;
   // internal ringer crossings come from a fixed half period
   always_comb begin
      if (ext_ring)
         zc = sync2_q[8] ^ zc_d_q;
      else
         zc = tick_q && ring_ms_q == lmc_pkg::RING_HALF_MS - 8'h1;
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ring_ms_q <= '0;
      end else if (tick_q) begin
         if (ring_ms_q == lmc_pkg::RING_HALF_MS - 8'h1)
            ring_ms_q <= '0;
         else
            ring_ms_q <= ring_ms_q + 8'h1;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         mode_q    <= lmc_pkg::MD_PD_HZ;
         ring_on_q <= 1'b0;
         trip_q    <= 1'b0;
         trip_zc_q <= '0;
      end else begin
         mode_q <= mode_eff;
         if (!is_ring(mode_eff))
            ring_on_q <= 1'b0;
         else if (zc)
            ring_on_q <= (mode_eff == lmc_pkg::MD_RING_BURST);
         // trip holds until the controller leaves ringing itself
         if (!is_ring(mode_req)) begin
            trip_q    <= 1'b0;
            trip_zc_q <= '0;
         end else if (ring_on_q && !trip_q) begin
            if (!hook_s)
               trip_zc_q <= '0;
            else if (zc && trip_zc_q == lmc_pkg::TRIP_ZC - 2'h1)
               trip_q <= 1'b1;
            else if (zc)
               trip_zc_q <= trip_zc_q + 2'h1;
         end
      end
   end

   // loop polarity and feed events
   wire pol_next = feed0_q[lmc_pkg::FEED0_POL] ^
        (mode_eff == lmc_pkg::MD_ACT_METER &&
         feed1_q[lmc_pkg::FEED1_KIND]);
   wire bb_sel = feed0_q[lmc_pkg::FEED0_BB];
   logic bb_q;
   wire mode_evt = (mode_eff != mode_q) ||
        (pol_next != polarity_rev) || (bb_sel != bb_q) ||
        (is_ring(mode_eff) && zc &&
         ring_on_q != (mode_eff == lmc_pkg::MD_RING_BURST));

   // persistence counters
   function automatic logic [8:0] reload(input logic [7:0] ms,
                                         input logic dbl);
      reload = dbl ? {ms, 1'b0} : {1'b0, ms};
   endfunction : reload

   logic [8:0] hook_cnt_q, gnk_cnt_q;
   logic       hook_prev_q, gnk_prev_q;
   wire [7:0]  hook_ms = is_pd(mode_eff) ? gnk_ms_q : dup_ms_q;
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         hook_cnt_q  <= {1'b0, lmc_pkg::GNK_RST_MS};
         gnk_cnt_q   <= {1'b0, lmc_pkg::GNK_RST_MS};
         hook_prev_q <= 1'b0;
         gnk_prev_q  <= 1'b0;
         hook_q      <= 1'b0;
         gnk_q       <= 1'b0;
         bb_q        <= 1'b0;
      end else begin
         hook_prev_q <= hook_s;
         gnk_prev_q  <= gnk_s;
         bb_q        <= bb_sel;
         // a mode change freezes hook and doubles its countdown
         if (mode_evt)
            hook_cnt_q <= reload(hook_ms, 1'b1);
         else if (hook_s != hook_prev_q)
            hook_cnt_q <= reload(hook_ms, 1'b0);
         else if (tick_q) begin
            if (hook_cnt_q == '0) begin
               hook_q     <= hook_s;
               hook_cnt_q <= reload(hook_ms, 1'b0);
            end else
               hook_cnt_q <= hook_cnt_q - 9'h1;
         end
         if (is_pd(mode_eff)) begin
            gnk_q     <= 1'b0;
            gnk_cnt_q <= reload(gnk_ms_q, 1'b0);
         end else if (gnk_s != gnk_prev_q)
            gnk_cnt_q <= reload(gnk_ms_q, 1'b0);
         else if (tick_q) begin
            if (gnk_cnt_q == '0) begin
               gnk_q     <= gnk_s;
               gnk_cnt_q <= reload(gnk_ms_q, 1'b0);
            end else
               gnk_cnt_q <= gnk_cnt_q - 9'h1;
         end
      end
   end

   // signalling register and summary interrupt
   logic hook_seen_q, gnk_seen_q;
   wire  hook_tg = hook_q ^ hook_seen_q;
   wire  gnk_tg  = gnk_q ^ gnk_seen_q;
   wire  unmasked = (hook_tg & ~mask_q[lmc_pkg::SIG_HOOK]) |
                    (gnk_tg & ~mask_q[lmc_pkg::SIG_GNK]);
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sig_q       <= 3'h2;
         signalling_summary_irq_q      <= 1'b1;
         hook_seen_q <= 1'b0;
         gnk_seen_q  <= 1'b0;
      end else begin
         hook_seen_q <= hook_q;
         gnk_seen_q  <= gnk_q;
         // a toggle in the clearing cycle survives the clear
         if (rd_sig)
            sig_q <= '0;
         if (hook_tg)
            sig_q[lmc_pkg::SIG_HOOK] <= 1'b1;
         if (gnk_tg)
            sig_q[lmc_pkg::SIG_GNK] <= 1'b1;
         if (unmasked)
            signalling_summary_irq_q <= 1'b1;
         else if (rd_sig)
            signalling_summary_irq_q <= 1'b0;
      end
   end

   // upstream status byte; pins that pio_q sets as outputs read back as 1
   always_comb begin
      up_byte = '0;
      up_byte[lmc_pkg::UP_IO2]  = pio_q[3] | sync2_q[7];
      up_byte[lmc_pkg::UP_IO1]  = pio_q[2] | sync2_q[6];
      up_byte[lmc_pkg::UP_IN1]  = sync2_q[5];
      up_byte[lmc_pkg::UP_HOOK] = hook_q;
      up_byte[lmc_pkg::UP_GNK]  = gnk_q;
      up_byte[lmc_pkg::UP_SIGNALLING_SUMMARY_IRQ] = signalling_summary_irq_q;
   end

   // read data, registered while waitrequest is high
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst)
         avs_readdata <= '0;
      else if (avs_read && avs_waitrequest) begin
         unique case (avs_address)
            lmc_pkg::FEED0_OFS:   avs_readdata <= {24'h0, feed0_q};
            lmc_pkg::FEED1_OFS:   avs_readdata <= {24'h0, feed1_q};
            lmc_pkg::EXT2_OFS:    avs_readdata <= {24'h0, ext2_q};
            lmc_pkg::SIG_OFS:     avs_readdata <= {29'h0, sig_q};
            lmc_pkg::MASK_OFS:    avs_readdata <= {29'h0, mask_q};
            lmc_pkg::PERSIST_OFS:
               avs_readdata <= {16'h0, gnk_ms_q, dup_ms_q};
            lmc_pkg::PIO_OFS:
               avs_readdata <= {27'h0, fixed_val_q, pio_q};
            lmc_pkg::STAT_OFS:
               avs_readdata <= {11'h0, trip_q, ring_on_q,
                                downstream_command_byte_q, mode_q, up_byte};
            default:              avs_readdata <= '0;
         endcase
      end
   end

   // line driver and pin outputs
   logic [3:0] code;
   always_comb begin
      unique case (mode_eff)
         lmc_pkg::MD_PD_HZ:     code = lmc_pkg::POWERDOWN_HIGH_Z_CODE;
         lmc_pkg::MD_PD_RES:    code = lmc_pkg::POWERDOWN_RESISTIVE_CODE;
         lmc_pkg::MD_GND_START: code = lmc_pkg::HIT_CODE;
         lmc_pkg::MD_RING_PAUSE,
         lmc_pkg::MD_RING_BURST: code = lmc_pkg::BB_CODE;
         default: code = bb_sel ? lmc_pkg::BB_CODE
                                : lmc_pkg::ACT_CODE;
      endcase
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         {line_ctrl_pin1, line_ctrl_pin2} <= lmc_pkg::POWERDOWN_HIGH_Z_CODE;
         polarity_rev    <= 1'b0;
         ac_loop_on      <= 1'b0;
         dc_loop_on      <= 1'b0;
         voice_loopback  <= 1'b1;
         ring_burst_on   <= 1'b0;
         mulaw_sel       <= 1'b0;
         teletax_on      <= 1'b0;
         meter_tone_sel  <= 1'b0;
         meter_slope_off <= 1'b0;
         fixed_out_o     <= 1'b0;
         fixed_out_oe    <= 1'b0;
         frontend_io_pin1_o  <= 1'b0;
         frontend_io_pin1_oe <= 1'b0;
         frontend_io_pin2_o  <= 1'b0;
         frontend_io_pin2_oe <= 1'b0;
      end else begin
         {line_ctrl_pin1, line_ctrl_pin2} <= code;
         polarity_rev   <= pol_next;
         ac_loop_on     <= !is_pd(mode_eff) && !is_ring(mode_eff);
         dc_loop_on     <= !is_pd(mode_eff) && !is_ring(mode_eff);
         voice_loopback <= is_pd(mode_eff) || is_ring(mode_eff);
         // burst drops with the line code when ringing is left
         ring_burst_on  <= ring_on_q && is_ring(mode_eff);
         mulaw_sel      <= feed0_q[lmc_pkg::FEED0_LAW];
         teletax_on     <= mode_eff == lmc_pkg::MD_ACT_METER &&
                           !feed1_q[lmc_pkg::FEED1_KIND];
         meter_tone_sel  <= feed1_q[lmc_pkg::FEED1_TONE];
         meter_slope_off <= feed1_q[lmc_pkg::FEED1_METER_SLOPE_DISABLE];
         fixed_out_o     <= fixed_val_q;
         fixed_out_oe    <= sop_seen_q;
         frontend_io_pin1_o  <= ext_ring ? ring_on_q : pio_q[0];
         frontend_io_pin1_oe <= ext_ring | pio_q[2];
         frontend_io_pin2_o  <= pio_q[1];
         frontend_io_pin2_oe <= pio_q[3];
      end
   end
endmodule : lmc_line_mode_ctrl

// *** dv/lmc_line_mode_ctrl_assertions.sv ***
// port checks for the line mode controller
module lmc_line_mode_ctrl_assertions (
   // clock and reset
   input wire logic        core_clk,
   input wire logic        sys_rst,
   // register bus
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // line side
   input wire logic        link_du_oe,
   input wire logic [1:0]  line_ctrl_pin1,
   input wire logic [1:0]  line_ctrl_pin2,
   input wire logic        polarity_rev,
   input wire logic        ac_loop_on,
   input wire logic        voice_loopback,
   input wire logic        ring_burst_on,
   input wire logic        mulaw_sel,
   input wire logic        teletax_on
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);
   logic [3:0] code;
   assign code = {line_ctrl_pin1, line_ctrl_pin2};
   wait_pulse_a: assert property (
      !avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low longer than one cycle");
   wait_answer_a: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered in one cycle");
   bus_idle_a: assert property (
      !(avs_read || avs_write) |-> avs_waitrequest)
      else $error("waitrequest low without request");
   rd_upper_a: assert property (
      avs_read && !avs_waitrequest |-> avs_readdata[31:21] == 11'h0)
      else $error("read upper bits set");
   rst_powerdown_high_z_a: assert property (
      $fell(sys_rst) |-> code == lmc_pkg::POWERDOWN_HIGH_Z_CODE && !polarity_rev &&
      !mulaw_sel) else $error("reset line state wrong");
   du_oe_keep_a: assert property (link_du_oe |=> link_du_oe)
      else $error("upstream driver released");
   pd_loop_a: assert property (
      code == lmc_pkg::POWERDOWN_HIGH_Z_CODE |-> voice_loopback && !ac_loop_on)
      else $error("power down loops wrong");
   ring_off_a: assert property (
      ring_burst_on |-> !ac_loop_on && code == lmc_pkg::BB_CODE)
      else $error("ring loops wrong");
   hit_act_a: assert property (
      code == lmc_pkg::HIT_CODE |-> ac_loop_on && !voice_loopback)
      else $error("ground start not active");
   tone_act_a: assert property (
      teletax_on |-> ac_loop_on && !ring_burst_on)
      else $error("tone outside active");
endmodule : lmc_line_mode_ctrl_assertions

// *** dv/lmc_lc_model.sv ***
// line card controller model on the serial command link
module lmc_lc_model (
   // link toward the device
   output logic link_clk,
   output logic link_fs,
   output logic link_dd,
   // upstream data from the device
   input  wire logic link_du_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // upstream byte of the last frame, msb first
   logic [7:0] up_seen;
   initial begin
      link_clk = 1'b0;
      link_fs  = 1'b0;
      link_dd  = 1'b1;
      up_seen  = '0;
   end
   // clock stands still between frames; released data shows the inverse
   task automatic send_byte(input logic [7:0] b);
      #3;
      for (int i = 7; i >= 0; i--) begin
         link_dd = b[i];
         link_fs = (i == 7);
         #40 link_clk = 1'b1;
         #40;
         // sampled late in the bit, well after the device moved it
         if (i < 7)
            up_seen = {up_seen[6:0], link_du_o};
         link_clk = 1'b0;
      end
      link_fs = 1'b0;
      link_dd = ~b[0];
      #40 up_seen = {up_seen[6:0], link_du_o};
   endtask : send_byte
endmodule : lmc_lc_model

// *** dv/tb_top.sv ***
// self-checking bench for the line mode controller
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0;
   logic        avs_write = 1'b0, hook_raw = 1'b0, processor_io_pin1 = 1'b0;
   logic [4:0]  avs_address = 5'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, v;
   logic        avs_waitrequest, link_clk, link_fs, link_dd, link_du_o;
   logic        link_du_oe, polarity_rev, ac_loop_on, dc_loop_on;
   logic        voice_loopback, ring_burst_on, mulaw_sel, teletax_on;
   logic        meter_tone_sel, meter_slope_off, fixed_out_o, fixed_out_oe;
   logic        frontend_io_pin1_o, frontend_io_pin1_oe, frontend_io_pin1_i;
   logic        frontend_io_pin2_o, frontend_io_pin2_oe, frontend_io_pin2_i;
   logic [1:0]  line_ctrl_pin1, line_ctrl_pin2;
   logic        gnd_key_raw = 1'b0, in1_pin = 1'b0;
   int          mismatches = 0, cmp_count = 0;
   // undriven io pins rest low through the board pull-down
   assign frontend_io_pin1_i = frontend_io_pin1_oe & frontend_io_pin1_o;
   assign frontend_io_pin2_i = frontend_io_pin2_oe & frontend_io_pin2_o;
   always #5 core_clk = ~core_clk;
   lmc_line_mode_ctrl #(.TICK_CYC(10)) lmc_line_mode_ctrl_inst (.*);
   lmc_lc_model lmc_lc_model_inst (.*);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic close_out();
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : close_out
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cyc
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      v = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      @(posedge core_clk);
   endtask : bus
   task automatic mode(input logic [2:0] m);
      lmc_lc_model_inst.send_byte({3'h0, m, 2'h0});
      cyc(10);
   endtask : mode
   task automatic t_reset();
      mode(3'h0);
      chk(lmc_lc_model_inst.up_seen, lmc_pkg::UP_RST);
      bus(0, lmc_pkg::SIG_OFS, 0);
      chk(v, 32'h2);
      bus(0, lmc_pkg::SIG_OFS, 0);
      chk(v, 32'h0);
      bus(0, lmc_pkg::MASK_OFS, 0);
      chk(v, 32'h7);
      bus(0, lmc_pkg::PERSIST_OFS, 0);
      chk(v, 32'h140a);
      bus(0, 5'h02, 0);
      chk(v, 32'h0);
      chk({line_ctrl_pin1, line_ctrl_pin2, polarity_rev, mulaw_sel, fixed_out_oe,
           frontend_io_pin1_oe}, {lmc_pkg::POWERDOWN_HIGH_Z_CODE, 4'h0});
      bus(1, lmc_pkg::PIO_OFS, 32'h1a);
      cyc(2);
      chk({fixed_out_o, fixed_out_oe, frontend_io_pin2_o,
           frontend_io_pin2_oe}, 4'hf);
      bus(1, lmc_pkg::PIO_OFS, 0);
   endtask : t_reset
   task automatic t_hook();
      hook_raw <= 1'b1;
      cyc(150);
      bus(0, lmc_pkg::STAT_OFS, 0);
      chk(v[10:0], {3'(lmc_pkg::MD_PD_HZ), 8'h00});
      cyc(100);
      bus(0, lmc_pkg::STAT_OFS, 0);
      chk(v[4], 1);
      hook_raw <= 1'b0;
   endtask : t_hook
   task automatic t_modes();
      logic [2:0] ms[7] = '{3'h7, 3'h2, 3'h6, 3'h4, 3'h1, 3'h3, 3'h0};
      logic [3:0] ec[7] = '{lmc_pkg::POWERDOWN_RESISTIVE_CODE, lmc_pkg::ACT_CODE,
         lmc_pkg::ACT_CODE, lmc_pkg::HIT_CODE, lmc_pkg::BB_CODE,
         lmc_pkg::POWERDOWN_HIGH_Z_CODE, lmc_pkg::POWERDOWN_HIGH_Z_CODE};
      logic       ea[7] = '{0, 1, 1, 1, 0, 0, 0};
      for (int i = 0; i < 7; i++) begin
         mode(ms[i]);
         chk({line_ctrl_pin1, line_ctrl_pin2, ac_loop_on, dc_loop_on, voice_loopback,
              teletax_on}, {ec[i], ea[i], ea[i], !ea[i], ms[i] == 3'h6});
      end
      bus(1, lmc_pkg::FEED1_OFS, 32'he0);
      mode(3'h6);
      chk({polarity_rev, meter_tone_sel, meter_slope_off},
          3'h7);
      mode(3'h2);
      bus(1, lmc_pkg::FEED0_OFS, 32'hc0);
      cyc(3);
      chk({line_ctrl_pin1, line_ctrl_pin2, polarity_rev},
          {lmc_pkg::BB_CODE, 1'b1});
      bus(1, lmc_pkg::FEED0_OFS, 0);
   endtask : t_modes
   task automatic t_ring();
      mode(3'h5);
      for (int i = 0; i < 300 && ring_burst_on !== 1'b1; i++) @(posedge core_clk);
      chk(ring_burst_on, 1);
      hook_raw <= 1'b1;
      for (int i = 0; i < 900 && ring_burst_on !== 1'b0; i++) @(posedge core_clk);
      cyc(3);
      chk({line_ctrl_pin1, line_ctrl_pin2, ring_burst_on, ac_loop_on},
          {lmc_pkg::ACT_CODE, 2'h1});
      hook_raw <= 1'b0;
      // a trip holds until the controller leaves ringing
      mode(3'h2);
      bus(1, lmc_pkg::EXT2_OFS, 32'h80);
      mode(3'h5);
      for (int i = 0; i < 40 && frontend_io_pin1_i !== 1'b1; i++) begin
         processor_io_pin1 <= !processor_io_pin1;
         cyc(20);
      end
      chk({frontend_io_pin1_oe, frontend_io_pin1_o}, 2'h3);
      // pause: the burst runs on until the next crossing
      mode(3'h1);
      chk(ring_burst_on, 1);
      processor_io_pin1 <= !processor_io_pin1;
      cyc(8);
      chk({ring_burst_on, frontend_io_pin1_o}, 2'h0);
      mode(3'h0);
   endtask : t_ring
   initial begin
      cyc(10);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      t_reset();
      t_hook();
      t_modes();
      t_ring();
      close_out();
   end
   // the tests need about 2500 cycles; allow twenty times that
   initial begin
      #500us;
      mismatches++;
      close_out();
   end
endmodule : tb_top
bind lmc_line_mode_ctrl lmc_line_mode_ctrl_assertions
   lmc_line_mode_ctrl_assertions_inst (.*);
